// [logic/tsf_filter_top.v]
// touch sample filter: rank/mean post-processing, aux/battery result, limit alarm and shared gpio pin
// assumes conversion results arrive as one-cycle strobes from an outside converter
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "tsf_regs.vh"
module tsf_filter_top #(
	parameter DATA_W = 12,
	parameter SORT_CYCLES = `TSF_SORT_CYCLES
) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire [3:0] reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [15:0] reg_rdata_out,
	input wire conv_start_in,
	input wire conv_valid_in,
	input wire [DATA_W-1:0] conv_data_in,
	output wire conv_req_out,
	output wire sampling_out,
	output wire [2:0] channel_out,
	output wire batt_div_en_out,
	output wire busy_out,
	output reg done_out,
	output wire alarm_n_out,
	input wire gpio_pin_in,
	output wire gpio_pin_out,
	output wire gpio_pin_oe_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_SORT = 2'h2;
	localparam ST_DONE = 2'h3;

	reg [15:0] ctrl1_reg;
	reg [15:0] ctrl2_reg;
	reg [3:0] ctrl3_reg;
	reg [15:0] upper_reg;
	reg [15:0] lower_reg;
	reg [DATA_W-1:0] result_reg;
	reg [DATA_W-1:0] sample_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [4:0] taken_reg;
	reg [8:0] sort_cnt_reg;
	reg [4:0] total;
	reg [4:0] med_cnt;
	reg [4:0] avg_cnt;
	reg wr_ctrl2;
	reg wr_ctrl3;
	reg hi_hit;
	reg lo_hit;
	reg aux_done;
	wire [DATA_W-1:0] mean;
	wire [2:0] chan;
	wire gpio_en;
	wire dir_in;
	wire pol;
	wire [15:0] ctrl2_view;
	wire [15:0] ctrl3_rst;

	assign ctrl3_rst = `TSF_CTRL3_RST;

	assign chan = ctrl1_reg[`TSF_CHAN_HI:`TSF_CHAN_LO];
	assign gpio_en = ctrl2_reg[`TSF_GPIO_EN_BIT];
	assign dir_in = ctrl2_reg[`TSF_DIR_BIT];
	assign pol = ctrl2_reg[`TSF_POL_BIT];

	// counts decoded from the fields; both fields zero takes a single sample, else a median count below the mean count falls back to the mean count
	always @* begin
		case (ctrl2_reg[`TSF_MED_HI:`TSF_MED_LO])
		2'h1: med_cnt = 5'h04;
		2'h2: med_cnt = 5'h08;
		2'h3: med_cnt = 5'h10;
		default: med_cnt = 5'h00;
		endcase
		case (ctrl2_reg[`TSF_AVG_HI:`TSF_AVG_LO])
		2'h1: avg_cnt = 5'h04;
		2'h2: avg_cnt = 5'h08;
		2'h3: avg_cnt = 5'h10;
		default: avg_cnt = 5'h02;
		endcase
		// a median count below the mean count runs the larger mean count as a plain average
		if (ctrl2_reg[`TSF_AVG_HI:`TSF_MED_LO] == 4'h0)
			total = 5'h01;
		else if (med_cnt < avg_cnt)
			total = avg_cnt;
		else
			total = med_cnt;
	end

	// sequencer: one conversion, one sort slot, repeat until the window is full
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (conv_start_in)
				state_next = ST_CONV;
		end
		ST_CONV: begin
			if (conv_valid_in)
				state_next = (total == 5'h01) ? ST_DONE : ST_SORT;
		end
		ST_SORT: begin
			if (sort_cnt_reg == 9'h001)
				state_next = (taken_reg == total) ? ST_DONE : ST_CONV;
		end
		ST_DONE: state_next = ST_IDLE;
		default: state_next = ST_IDLE;
		endcase
	end

	assign conv_req_out = (state_reg == ST_CONV);
	assign sampling_out = (state_reg == ST_CONV);
	assign channel_out = chan;
	// divider only burns current while the battery input is actually being sampled
	assign batt_div_en_out = (state_reg == ST_CONV) && (chan == `TSF_CHAN_BATT) && !gpio_en;
	assign busy_out = (state_reg != ST_IDLE);

	tsf_rank_sorter #(
		.DATA_W(DATA_W),
		.DEPTH(16)
	) u_sorter (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.clear_in(state_reg == ST_IDLE),
		.insert_in(state_reg == ST_CONV && conv_valid_in && total != 5'h01),
		.sample_in(conv_data_in),
		.count_in(total),
		.width_in((total == med_cnt) ? avg_cnt : total),
		.mean_out(mean)
	);

	always @* begin
		wr_ctrl2 = reg_wr_in && reg_addr_in == `TSF_ADDR_CTRL2;
		wr_ctrl3 = reg_wr_in && reg_addr_in == `TSF_ADDR_CTRL3;
		aux_done = (state_reg == ST_DONE) && !gpio_en && (chan == `TSF_CHAN_AUX || chan == `TSF_CHAN_BATT);
		hi_hit = aux_done && {{(16-DATA_W){1'b0}}, result_reg} > upper_reg;
		lo_hit = aux_done && {{(16-DATA_W){1'b0}}, result_reg} < lower_reg;
	end

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			taken_reg <= 5'h00;
			sort_cnt_reg <= 9'h000;
			sample_reg <= {DATA_W{1'b0}};
			result_reg <= {DATA_W{1'b0}};
			done_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			done_out <= (state_reg == ST_DONE);
			if (state_reg == ST_IDLE)
				taken_reg <= 5'h00;
			if (state_reg == ST_CONV && conv_valid_in) begin
				taken_reg <= taken_reg + 5'h01;
				sample_reg <= conv_data_in;
				sort_cnt_reg <= SORT_CYCLES[8:0];
			end else if (sort_cnt_reg != 9'h000) begin
				sort_cnt_reg <= sort_cnt_reg - 9'h001;
			end
			// result loads here once the whole window is done, or below at the strobe when a single sample is taken
			if (state_reg == ST_SORT && state_next == ST_DONE)
				result_reg <= mean;
			else if (state_reg == ST_CONV && conv_valid_in && total == 5'h01)
				result_reg <= conv_data_in;
		end
	end

	// gpio data bit follows the pin when an input; writes to it are dropped then
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl1_reg <= `TSF_CTRL1_RST;
			ctrl2_reg <= `TSF_CTRL2_RST;
			ctrl3_reg <= ctrl3_rst[3:0];
			upper_reg <= `TSF_BOUND_RST;
			lower_reg <= `TSF_BOUND_RST;
		end else begin
			if (reg_wr_in && reg_addr_in == `TSF_ADDR_CTRL1)
				ctrl1_reg <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `TSF_ADDR_UPPER)
				upper_reg <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == `TSF_ADDR_LOWER)
				lower_reg <= reg_wdata_in;
			if (wr_ctrl2) begin
				ctrl2_reg[15:13] <= reg_wdata_in[15:13];
				ctrl2_reg[11:0] <= reg_wdata_in[11:0];
				if (!(gpio_en && dir_in))
					ctrl2_reg[`TSF_DATA_BIT] <= reg_wdata_in[`TSF_DATA_BIT];
			end
			if (gpio_en && dir_in)
				ctrl2_reg[`TSF_DATA_BIT] <= pol ? gpio_pin_in : ~gpio_pin_in;
			// enables are plain writes; a flag write clears by writing one, but a new hit wins
			if (wr_ctrl3)
				ctrl3_reg[`TSF_LO_EN_BIT:`TSF_HI_EN_BIT] <= reg_wdata_in[`TSF_LO_EN_BIT:`TSF_HI_EN_BIT];
			ctrl3_reg[`TSF_HI_FLAG_BIT] <= hi_hit |
				(ctrl3_reg[`TSF_HI_FLAG_BIT] & ~(wr_ctrl3 & reg_wdata_in[`TSF_HI_FLAG_BIT]));
			ctrl3_reg[`TSF_LO_FLAG_BIT] <= lo_hit |
				(ctrl3_reg[`TSF_LO_FLAG_BIT] & ~(wr_ctrl3 & reg_wdata_in[`TSF_LO_FLAG_BIT]));
		end
	end

	assign alarm_n_out = ~((ctrl3_reg[`TSF_HI_FLAG_BIT] & ctrl3_reg[`TSF_HI_EN_BIT]) |
		(ctrl3_reg[`TSF_LO_FLAG_BIT] & ctrl3_reg[`TSF_LO_EN_BIT]));
	// pin stays undriven unless gpio is enabled as an output
	assign gpio_pin_oe_out = gpio_en & ~dir_in;
	assign gpio_pin_out = pol ? ctrl2_reg[`TSF_DATA_BIT] : ~ctrl2_reg[`TSF_DATA_BIT];
	assign ctrl2_view = ctrl2_reg;

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
			`TSF_ADDR_CTRL1: reg_rdata_out <= ctrl1_reg;
			`TSF_ADDR_CTRL2: reg_rdata_out <= ctrl2_view;
			`TSF_ADDR_CTRL3: reg_rdata_out <= {12'h000, ctrl3_reg};
			`TSF_ADDR_UPPER: reg_rdata_out <= upper_reg;
			`TSF_ADDR_LOWER: reg_rdata_out <= lower_reg;
			`TSF_ADDR_RESULT: reg_rdata_out <= {{(16-DATA_W){1'b0}}, result_reg};
			`TSF_ADDR_SAMPLE: reg_rdata_out <= {{(16-DATA_W){1'b0}}, sample_reg};
			default: reg_rdata_out <= 16'h0000;
			endcase
		end
	end
endmodule // tsf_filter_top

// [logic/tsf_regs.vh]
// register map, field positions, reset values and timing counts of the touch sample filter
// assumes a 200 MHz system clock and a 4-bit register index on the plain register port
`ifndef TSF_REGS_VH
`define TSF_REGS_VH
`define TSF_ADDR_CTRL1 4'h1
`define TSF_ADDR_CTRL2 4'h2
`define TSF_ADDR_CTRL3 4'h3
`define TSF_ADDR_UPPER 4'h4
`define TSF_ADDR_LOWER 4'h5
`define TSF_ADDR_RESULT 4'hc
`define TSF_ADDR_SAMPLE 4'h8
`define TSF_CTRL1_RST 16'h0000
`define TSF_CTRL2_RST 16'h4040
`define TSF_CTRL3_RST 16'h0000
`define TSF_BOUND_RST 16'h0000
`define TSF_CHAN_HI 14
`define TSF_CHAN_LO 12
`define TSF_CHAN_BATT 3'h2
`define TSF_CHAN_AUX 3'h3
`define TSF_MED_HI 6
`define TSF_MED_LO 5
`define TSF_AVG_HI 8
`define TSF_AVG_LO 7
`define TSF_POL_BIT 10
`define TSF_DIR_BIT 11
`define TSF_DATA_BIT 12
`define TSF_GPIO_EN_BIT 13
`define TSF_HI_FLAG_BIT 0
`define TSF_LO_FLAG_BIT 1
`define TSF_HI_EN_BIT 2
`define TSF_LO_EN_BIT 3
`define TSF_SORT_NS 2000
`define TSF_CLK_NS 5
`define TSF_SORT_CYCLES ((`TSF_SORT_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS)
`endif

// [logic/tsf_rank_sorter.v]
// insertion-sorted sample array with windowed mean of the centre entries
// assumes one insert pulse at a time and a clear before each new channel
`timescale 1ns/1ps
`include "tsf_regs.vh"
module tsf_rank_sorter #(
	parameter DATA_W = 12,
	parameter DEPTH = 16
) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire clear_in,
	input wire insert_in,
	input wire [DATA_W-1:0] sample_in,
	input wire [4:0] count_in,
	input wire [4:0] width_in,
	output reg [DATA_W-1:0] mean_out
);
	reg [DATA_W-1:0] arr_reg [0:DEPTH-1];
	reg [4:0] fill_reg;
	reg [DATA_W+4:0] sum;
	reg [4:0] first;
	reg [2:0] shift;
	reg [DATA_W+4:0] shifted;
	integer i;
	integer k;

	// smallest in slot 0, largest in slot fill-1; a new sample shifts larger ones up
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			fill_reg <= 5'h00;
			for (i = 0; i < DEPTH; i = i + 1)
				arr_reg[i] <= {DATA_W{1'b0}};
		end else if (clear_in) begin
			fill_reg <= 5'h00;
		end else if (insert_in) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				if (i < fill_reg && arr_reg[i] > sample_in)
					arr_reg[(i + 1) % DEPTH] <= arr_reg[i];
				if (i < fill_reg && arr_reg[i] <= sample_in && (i + 1 == fill_reg || arr_reg[(i + 1) % DEPTH] > sample_in))
					arr_reg[(i + 1) % DEPTH] <= sample_in;
			end
			if (fill_reg == 5'h00 || arr_reg[0] > sample_in)
				arr_reg[0] <= sample_in;
			fill_reg <= fill_reg + 5'h01;
		end
	end

	// centre window of the sorted array; equal count and width means the plain average
	always @* begin
		sum = {(DATA_W+5){1'b0}};
		first = (count_in - width_in) >> 1;
		shift = 3'h0;
		shifted = {(DATA_W+5){1'b0}};
		for (k = 0; k < DEPTH; k = k + 1)
			if (k >= first && k < first + width_in)
				sum = sum + {5'h00, arr_reg[k]};
		for (k = 1; k < 5; k = k + 1)
			if (width_in == (5'h01 << k))
				shift = k[2:0];
		// the mean of 12-bit samples never exceeds 12 bits, so the cut drops only zeros
		shifted = sum >> shift;
		mean_out = shifted[DATA_W-1:0];
	end
endmodule // tsf_rank_sorter

// [tb/tsf_filter_asserts.sv]
// port checker for the touch sample filter top
// assumes it is bound to tsf_filter_top
`timescale 1ns/1ps
module tsf_filter_asserts (
	input wire clk_sys_in,
	input wire rst_in,
	input wire [3:0] reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [15:0] reg_rdata_out,
	input wire conv_start_in,
	input wire conv_valid_in,
	input wire conv_req_out,
	input wire sampling_out,
	input wire [2:0] channel_out,
	input wire batt_div_en_out,
	input wire busy_out,
	input wire done_out,
	input wire alarm_n_out,
	input wire gpio_pin_oe_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_batt_div: assert property (batt_div_en_out |-> sampling_out && channel_out == 3'h2 && !gpio_pin_oe_out)
		else $error("divider on outside battery sampling");
	a_req_busy: assert property (conv_req_out |-> busy_out && sampling_out) else $error("request while idle");
	a_start_req: assert property (conv_start_in && !busy_out |=> conv_req_out) else $error("start not taken");
	a_req_hold: assert property (conv_req_out && !conv_valid_in |=> conv_req_out) else $error("request dropped");
	a_sort_gap: assert property (conv_req_out && conv_valid_in |=> !conv_req_out [*2])
		else $error("no sort time after sample");
	a_done_once: assert property (done_out |-> $past(busy_out) ##1 !done_out) else $error("done not a pulse");
	a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
	a_alarm_cause: assert property ($fell(alarm_n_out) |-> done_out || $past(reg_wr_in))
		else $error("alarm without cause");
	a_oe_write: assert property ($rose(gpio_pin_oe_out) |-> $past(reg_wr_in) && $past(reg_addr_in) == 4'h2
		&& $past(reg_wdata_in[13]) && !$past(reg_wdata_in[11])) else $error("pin driven without setup");
	c_done: cover property (done_out);
	c_alarm: cover property ($fell(alarm_n_out));
	c_drive: cover property ($rose(gpio_pin_oe_out));
	c_batt: cover property (batt_div_en_out);
endmodule // tsf_filter_asserts
bind tsf_filter_top tsf_filter_asserts i_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.conv_start_in(conv_start_in), .conv_valid_in(conv_valid_in), .conv_req_out(conv_req_out),
	.sampling_out(sampling_out), .channel_out(channel_out), .batt_div_en_out(batt_div_en_out), .busy_out(busy_out),
	.done_out(done_out), .alarm_n_out(alarm_n_out), .gpio_pin_oe_out(gpio_pin_oe_out));

// [tb/tsf_conv_model.sv]
// converter model answering conversion requests from a sample queue
// assumes the bench fills samples before starting a measurement
`timescale 1ns/1ps
module tsf_conv_model (
	input wire clk_sys_in,
	input wire rst_in,
	input wire conv_req_in,
	output logic conv_valid_out,
	output logic [11:0] conv_data_out
);
	logic [11:0] samples[$];
	int wait_cnt;
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			conv_valid_out <= 1'b0;
			conv_data_out <= 12'h000;
			wait_cnt <= 0;
		end else begin
			conv_valid_out <= 1'b0;
			// data is not held after the strobe
			conv_data_out <= ~conv_data_out;
			if (conv_req_in && !conv_valid_out && samples.size() > 0) begin
				if (wait_cnt == 0) begin
					conv_valid_out <= 1'b1;
					conv_data_out <= samples[0];
					// mix prompt and slow answers
					wait_cnt <= samples.size() % 3;
					void'(samples.pop_front());
				end else begin
					wait_cnt <= wait_cnt - 1;
				end
			end
		end
	end
endmodule // tsf_conv_model

// [tb/touch_sample_filter_aux_gpio_tb.sv]
// self-checking bench for the touch sample filter top
// assumes the converter model on the conversion port
`timescale 1ns/1ps
module touch_sample_filter_aux_gpio_tb;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic start = 1'b0;
	logic pin_drv = 1'b0;
	logic rd_seen = 1'b0;
	wire [15:0] rdata;
	wire valid, req, done, alarm_n, pin_out, pin_oe, div_en;
	wire [11:0] cdata;
	wire pin_wire = pin_oe ? pin_out : pin_drv;
	logic [15:0] exp_q[$];
	logic [11:0] s[16];
	logic [15:0] g_wr[8] = '{16'h2000, 16'h3000, 16'h3400, 16'h2c00, 16'h3c00, 16'h2800, 16'h2800, 16'h0000};
	// the data bit keeps its last input value when the pin is handed back to the analog side
	logic [15:0] g_rd[8] = '{16'h2000, 16'h3000, 16'h3400, 16'h3c00, 16'h2c00, 16'h2800, 16'h3800, 16'h1000};
	logic [2:0] g_ctl[8] = '{3'b011, 3'b001, 3'b011, 3'b100, 3'b000, 3'b100, 3'b000, 3'b000};
	int errors = 0, checks = 0, seed = 89916, m, a, dv = 0, d0 = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	tsf_filter_top #(.DATA_W(12), .SORT_CYCLES(2)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.conv_start_in(start), .conv_valid_in(valid), .conv_data_in(cdata), .conv_req_out(req), .sampling_out(),
		.channel_out(), .batt_div_en_out(div_en), .busy_out(), .done_out(done), .alarm_n_out(alarm_n),
		.gpio_pin_in(pin_wire), .gpio_pin_out(pin_out), .gpio_pin_oe_out(pin_oe));
	tsf_conv_model i_conv (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .conv_req_in(req), .conv_valid_out(valid),
		.conv_data_out(cdata));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk_sys_in);
		addr <= ad;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_sys_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [15:0] e);
		@(posedge clk_sys_in);
		exp_q.push_back(e);
		addr <= ad;
		rd_s <= 1'b1;
		@(posedge clk_sys_in);
		rd_s <= 1'b0;
	endtask
	task automatic meas();
		@(posedge clk_sys_in);
		start <= 1'b1;
		@(posedge clk_sys_in);
		start <= 1'b0;
		for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge clk_sys_in);
		if (done !== 1'b1) begin
			errors++;
			print_verdict();
		end
	endtask
	// sorts s in place, then means the centre window
	function automatic logic [11:0] fexp(input int m, input int a);
		logic [15:0] sum = 16'h0000;
		logic [11:0] t;
		for (int i = 0; i < m; i++)
			for (int j = 0; j + 1 < m - i; j++)
				if (s[j] > s[j+1]) begin
					t = s[j];
					s[j] = s[j+1];
					s[j+1] = t;
				end
		for (int i = (m - a) / 2; i < (m + a) / 2; i++) sum += 16'(s[i]);
		return 12'(sum >> $clog2(a));
	endfunction
	// counts divider-on cycles so battery and aux runs can be told apart
	always @(posedge clk_sys_in) begin
		if (div_en === 1'b1) dv <= dv + 1;
	end
	always @(posedge clk_sys_in) begin
		rd_seen <= rd_s;
		if (rd_seen && exp_q.size() > 0) check(rdata, exp_q.pop_front());
	end
	initial begin
		repeat (8) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(4'h2, 16'h4040);
		rd(4'hf, 16'h0000);
		wr(4'h4, 16'h0fff);
		wr(4'h1, 16'h3000);
		for (int med = 1; med < 4; med++) begin
			for (int avg = 0; avg <= med; avg++) begin
				m = 2 << med;
				a = 2 << avg;
				wr(4'h2, 16'h4000 | 16'(avg << 7) | 16'(med << 5));
				for (int i = 0; i < m; i++) begin
					s[i] = 12'($random(seed));
					i_conv.samples.push_back(s[i]);
				end
				meas();
				rd(4'hc, {4'h0, fexp(m, a)});
			end
		end
		check(16'(dv), 16'h0000);
		$display("filter test done");
		wr(4'h1, 16'h2000);
		wr(4'h2, 16'h4000);
		wr(4'h4, 16'h0800);
		wr(4'h5, 16'h0100);
		wr(4'h3, 16'h0004);
		i_conv.samples.push_back(12'h900);
		meas();
		rd(4'hc, 16'h0900);
		check(dv != 0, 1'b1);
		d0 = dv;
		rd(4'h3, 16'h0005);
		check(alarm_n, 1'b0);
		wr(4'h3, 16'h0009);
		wr(4'h1, 16'h3000);
		i_conv.samples.push_back(12'h050);
		meas();
		rd(4'hc, 16'h0050);
		check(dv == d0, 1'b1);
		rd(4'h3, 16'h000a);
		check(alarm_n, 1'b0);
		wr(4'h3, 16'h0000);
		rd(4'h3, 16'h0002);
		check(alarm_n, 1'b1);
		$display("limit test done");
		for (int i = 0; i < 8; i++) begin
			pin_drv <= g_ctl[i][2];
			wr(4'h2, g_wr[i]);
			rd(4'h2, g_rd[i]);
			check(pin_oe, g_ctl[i][0]);
			if (g_ctl[i][0]) check(pin_out, g_ctl[i][1]);
		end
		$display("gpio test done");
		repeat (4) @(posedge clk_sys_in);
		print_verdict();
	end
endmodule // touch_sample_filter_aux_gpio_tb
